// ### hdl/lbt_defs.svh
// Register indices, field positions, masks and reset values of the
// layer blend and transparency block.
// Assumes byte address = 4 * index on a 32-bit AXI4-Lite register bus.
`ifndef LBT_DEFS_SVH
`define LBT_DEFS_SVH

// Register indices (byte address is four times the index)
`define LBT_IDX_TC0 10'h0BC
`define LBT_IDX_TC3 10'h0C0
`define LBT_IDX_TC2 10'h0C2
`define LBT_IDX_BLD2 10'h180
`define LBT_IDX_BLD3 10'h190
`define LBT_IDX_BLD4 10'h194
`define LBT_IDX_BLD5 10'h198
`define LBT_IDX_ETC0 10'h1A0

// Blend control fields
`define LBT_BR_MSB 7
`define LBT_BP_BIT 13
`define LBT_BI_BIT 14
`define LBT_BS_BIT 15
`define LBT_BE_BIT 16

// Transparency fields
`define LBT_TC_MSB 14
`define LBT_ZT_BIT 15
`define LBT_ETC_MSB 23
`define LBT_EZT_BIT 31

// Writable bit masks, every other bit reads zero
`define LBT_BLD_MASK 32'h0001E0FF
`define LBT_BLD5_MASK 32'h0001C0FF
`define LBT_TC_MASK 32'h0000FFFF
`define LBT_ETC_MASK 32'h80FFFFFF

// Reset values
`define LBT_BLD_RST 32'h00000000
`define LBT_TC_RST 16'h0000
`define LBT_ETC_HI_RST 9'h000

// Layer codes of the layer-order selection
`define LBT_LAYER0 4'h0
`define LBT_LAYER2 4'h2
`define LBT_LAYER3 4'h3
`define LBT_LAYER4 4'h4
`define LBT_LAYER5 4'h5

// Full-scale blend weight (ratio denominator)
`define LBT_FULL_WEIGHT 9'h100

// AXI responses
`define LBT_RESP_OKAY 2'h0
`define LBT_RESP_SLVERR 2'h2

`endif

// ### hdl/lbt_pkg.sv
// Types shared by the layer blend and transparency files.
// Assumes lbt_defs.svh is on the include path.
package lbt_pkg;

  // One colour component
  typedef logic [7:0] lbt_comp_t;

  // How a pixel is composed
  typedef enum logic [1:0] {
    LBT_PICK_UPPER = 2'b00,
    LBT_PICK_LOWER = 2'b01,
    LBT_PICK_BLEND = 2'b10
  } lbt_pick_t;

endpackage

// ### hdl/lbt_tcmp.sv
// Transparent colour comparator for one upper-layer pixel.
// Assumes the code and key are presented in the same clock cycle.
module lbt_tcmp (
  // Pixel colour code and programmed key
  input wire logic [23:0] code,
  input wire logic [23:0] key,
  input wire logic zero_opaque,
  // Pixel format
  input wire logic ind8,
  input wire logic wide24,
  // Result
  output logic transparent
);
  import lbt_pkg::*;

  logic match;
  logic is_zero;

  // Compare only the bits the pixel format really carries
  always_comb begin
    if (ind8) begin
      match = (code[7:0] == key[7:0]);
      is_zero = (code[7:0] == 8'h00);
    end else if (wide24) begin
      match = (code == key);
      is_zero = (code == 24'h000000);
    end else begin
      match = (code[14:0] == key[14:0]);
      is_zero = (code[14:0] == 15'h0000);
    end
    // Code 0 follows the zero bit alone, even if the key is also 0
    if (is_zero) begin
      transparent = ~zero_opaque;
    end else begin
      transparent = match;
    end
  end

endmodule // lbt_tcmp

// ### hdl/lbt_mix.sv
// Blend of one colour component of upper and lower images.
// Assumes the ratio is already incremented and lies in 0..256.
`include "lbt_defs.svh"
module lbt_mix #(
  parameter int W = 8
) (
  // Components
  input wire logic [W-1:0] upper,
  input wire logic [W-1:0] lower,
  // Weight in 256ths and expression select
  input wire logic [8:0] ratio,
  input wire logic swap,
  // Result
  output logic [W-1:0] result
);
  import lbt_pkg::*;

  logic [8:0] wt_up;
  logic [8:0] wt_lo;
  logic [W+9:0] sum;

  // Weights always add to 256, so the sum never exceeds W+8 bits
  always_comb begin
    if (swap) begin
      wt_up = `LBT_FULL_WEIGHT - ratio;
      wt_lo = ratio;
    end else begin
      wt_up = ratio;
      wt_lo = `LBT_FULL_WEIGHT - ratio;
    end
    sum = ({10'h000, upper} * {{W{1'b0}}, wt_up})
        + ({10'h000, lower} * {{W{1'b0}}, wt_lo});
    // Divide by 256 and drop fraction
    result = sum[W+7:8];
  end

endmodule // lbt_mix

// ### hdl/lbt_top.sv
// Layer blend and transparency control: registers over AXI4-Lite and a
// one-stage pixel composer for overlay layers.
// Assumes the layer order and pixels come from the display pipeline on
// sys_clk, and that srst is synchronous to sys_clk.
//
// How it works
// - Ratio equals eight-bit field over 256
// - Plane bit picks layer5 pixel as ratio
// - Layer5 control lacks plane select bit
// - Increment adds 1/256 to nonzero ratio
// - Select bit swaps the two weights
// - Enable bit chooses blending over overlay; key match still wins
// - Blend only pixels whose alpha is set
// - Key in low 15 bits; 8bpp low byte
// - Zero bit makes code 0 opaque
// - Key and zero bit clear: code 0 transparent
// - Layer0 key pixels transparent in blend mode
// - Layer0 extended key 24 bits, bit 31
// - Short and extended keys share storage
// - Upper layer comes from external order select
`include "lbt_defs.svh"
module lbt_top #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // AXI4-Lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  // AXI4-Lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // AXI4-Lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  // AXI4-Lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Pixel input from the layer pipeline
  input wire logic pix_valid,
  input wire logic [3:0] top_layer_select,
  input wire logic [23:0] upper_rgb,
  input wire logic [23:0] upper_code,
  input wire logic upper_alpha,
  input wire logic [23:0] lower_rgb,
  input wire logic [7:0] layer5_ratio_pix,
  input wire logic indirect_8bpp,
  input wire logic true_color_24,
  // Composed pixel
  output logic out_valid,
  output logic [23:0] out_rgb,
  output logic out_blended
);
  import lbt_pkg::*;

  // Register storage
  logic [31:0] bld_q [2:5]; // Blend controls, layers 2 to 5
  logic [31:0] bld_d [2:5];
  logic [15:0] tc0_q; // Shared low key and zero bit of layer 0
  logic [15:0] tc0_d;
  logic [15:0] tc2_q;
  logic [15:0] tc2_d;
  logic [15:0] tc3_q;
  logic [15:0] tc3_d;
  logic [8:0] etc0_hi_q; // Key bits 23..15 of layer 0
  logic [8:0] etc0_hi_d;

  // Bus state
  logic aw_have_q, aw_have_d;
  logic w_have_q, w_have_d;
  logic [ADDR_W-1:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic awready_q, awready_d;
  logic wready_q, wready_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic arready_q, arready_d;
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;

  // Word index of the pending write and of the read request
  logic [9:0] widx;
  logic [9:0] ridx;
  logic do_write;
  logic [31:0] etc0_img; // Extended view assembled from shared bits
  logic [31:0] merged;

  assign widx = awaddr_q[11:2];
  assign ridx = s_axi_araddr[11:2];
  assign do_write = aw_have_q & w_have_q;
  assign etc0_img = {tc0_q[`LBT_ZT_BIT], 7'h00, etc0_hi_q,
                     tc0_q[`LBT_TC_MSB:0]};

  // Byte-lane merge of write data into an old value, masked to live bits
  function automatic logic [31:0] lane_merge(input logic [31:0] old,
      input logic [31:0] data, input logic [3:0] strb,
      input logic [31:0] mask);
    logic [31:0] lanes;
    lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return ((old & ~lanes) | (data & lanes)) & mask;
  endfunction

  // Write channel: take address and data in either order, then commit
  always_comb begin
    aw_have_d = aw_have_q;
    w_have_d = w_have_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    merged = 32'h00000000;
    for (int i = 2; i <= 5; i++) begin
      bld_d[i] = bld_q[i];
    end
    tc0_d = tc0_q;
    tc2_d = tc2_q;
    tc3_d = tc3_q;
    etc0_hi_d = etc0_hi_q;
    // Response handed over
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    // Capture address
    if (s_axi_awvalid && awready_q) begin
      aw_have_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    // Capture data
    if (s_axi_wvalid && wready_q) begin
      w_have_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    // Commit once both halves are held
    if (do_write) begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = `LBT_RESP_OKAY;
      if (widx == `LBT_IDX_BLD2) begin
        bld_d[2] = lane_merge(bld_q[2], wdata_q, wstrb_q, `LBT_BLD_MASK);
      end else if (widx == `LBT_IDX_BLD3) begin
        bld_d[3] = lane_merge(bld_q[3], wdata_q, wstrb_q, `LBT_BLD_MASK);
      end else if (widx == `LBT_IDX_BLD4) begin
        bld_d[4] = lane_merge(bld_q[4], wdata_q, wstrb_q, `LBT_BLD_MASK);
      end else if (widx == `LBT_IDX_BLD5) begin
        // No plane select on layer 5
        bld_d[5] = lane_merge(bld_q[5], wdata_q, wstrb_q,
                              `LBT_BLD5_MASK);
      end else if (widx == `LBT_IDX_TC0) begin
        merged = lane_merge({16'h0000, tc0_q}, wdata_q, wstrb_q,
                            `LBT_TC_MASK);
        tc0_d = merged[15:0];
      end else if (widx == `LBT_IDX_TC2) begin
        merged = lane_merge({16'h0000, tc2_q}, wdata_q, wstrb_q,
                            `LBT_TC_MASK);
        tc2_d = merged[15:0];
      end else if (widx == `LBT_IDX_TC3) begin
        merged = lane_merge({16'h0000, tc3_q}, wdata_q, wstrb_q,
                            `LBT_TC_MASK);
        tc3_d = merged[15:0];
      end else if (widx == `LBT_IDX_ETC0) begin
        // Same flops as the short view, so both views always agree
        merged = lane_merge(etc0_img, wdata_q, wstrb_q, `LBT_ETC_MASK);
        tc0_d = {merged[`LBT_EZT_BIT], merged[`LBT_TC_MSB:0]};
        etc0_hi_d = merged[`LBT_ETC_MSB:15];
      end else begin
        // Unmapped word
        bresp_d = `LBT_RESP_SLVERR;
      end
    end
    // One write in flight: hold off both channels until response leaves
    awready_d = ~aw_have_d & ~bvalid_d;
    wready_d = ~w_have_d & ~bvalid_d;
  end

  // Read channel: answer one cycle after the address is taken
  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    if (s_axi_arvalid && arready_q) begin
      rvalid_d = 1'b1;
      rresp_d = `LBT_RESP_OKAY;
      if (ridx == `LBT_IDX_BLD2) begin
        rdata_d = bld_q[2];
      end else if (ridx == `LBT_IDX_BLD3) begin
        rdata_d = bld_q[3];
      end else if (ridx == `LBT_IDX_BLD4) begin
        rdata_d = bld_q[4];
      end else if (ridx == `LBT_IDX_BLD5) begin
        rdata_d = bld_q[5];
      end else if (ridx == `LBT_IDX_TC0) begin
        rdata_d = {16'h0000, tc0_q};
      end else if (ridx == `LBT_IDX_TC2) begin
        rdata_d = {16'h0000, tc2_q};
      end else if (ridx == `LBT_IDX_TC3) begin
        rdata_d = {16'h0000, tc3_q};
      end else if (ridx == `LBT_IDX_ETC0) begin
        rdata_d = etc0_img;
      end else begin
        rdata_d = 32'h00000000;
        rresp_d = `LBT_RESP_SLVERR;
      end
    end
    arready_d = ~rvalid_d;
  end

  // Bus and register flops
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `LBT_RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= `LBT_RESP_OKAY;
      for (int i = 2; i <= 5; i++) begin
        bld_q[i] <= `LBT_BLD_RST;
      end
      tc0_q <= `LBT_TC_RST;
      tc2_q <= `LBT_TC_RST;
      tc3_q <= `LBT_TC_RST;
      etc0_hi_q <= `LBT_ETC_HI_RST;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      for (int i = 2; i <= 5; i++) begin
        bld_q[i] <= bld_d[i];
      end
      tc0_q <= tc0_d;
      tc2_q <= tc2_d;
      tc3_q <= tc3_d;
      etc0_hi_q <= etc0_hi_d;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // Per-pixel parameters of the current upper layer
  logic [31:0] ctl; // Blend control of the upper layer, zero if none
  logic [23:0] key; // Transparent key of the upper layer
  logic key_zero_opaque;
  logic has_key;
  logic [7:0] base_ratio;
  logic [8:0] ratio;
  logic transparent;
  lbt_pick_t pick;
  logic [23:0] mix_rgb;

  // Upper layer parameters follow the external stacking order
  always_comb begin
    ctl = 32'h00000000;
    key = 24'h000000;
    key_zero_opaque = 1'b0;
    has_key = 1'b0;
    case (top_layer_select)
      `LBT_LAYER0: begin
        key = {etc0_hi_q, tc0_q[`LBT_TC_MSB:0]};
        key_zero_opaque = tc0_q[`LBT_ZT_BIT];
        has_key = 1'b1;
      end
      `LBT_LAYER2: begin
        ctl = bld_q[2];
        key = {9'h000, tc2_q[`LBT_TC_MSB:0]};
        key_zero_opaque = tc2_q[`LBT_ZT_BIT];
        has_key = 1'b1;
      end
      `LBT_LAYER3: begin
        ctl = bld_q[3];
        key = {9'h000, tc3_q[`LBT_TC_MSB:0]};
        key_zero_opaque = tc3_q[`LBT_ZT_BIT];
        has_key = 1'b1;
      end
      `LBT_LAYER4: ctl = bld_q[4];
      `LBT_LAYER5: ctl = bld_q[5];
      default: ctl = 32'h00000000;
    endcase
  end

  // Key compare; 24-bit keys exist only for layer 0
  lbt_tcmp u_tcmp (
    .code(upper_code),
    .key(key),
    .zero_opaque(key_zero_opaque),
    .ind8(indirect_8bpp),
    .wide24(true_color_24 && (top_layer_select == `LBT_LAYER0)),
    .transparent(transparent)
  );

  // Effective ratio and the choice of composition
  always_comb begin
    if (ctl[`LBT_BP_BIT]) begin
      base_ratio = layer5_ratio_pix;
    end else begin
      base_ratio = ctl[`LBT_BR_MSB:0];
    end
    // Ratio 0 stays 0 so a fully transparent weight remains exact
    if (ctl[`LBT_BI_BIT] && (base_ratio != 8'h00)) begin
      ratio = {1'b0, base_ratio} + 9'h001;
    end else begin
      ratio = {1'b0, base_ratio};
    end
    // Key match wins even in blend mode
    if (has_key && transparent) begin
      pick = LBT_PICK_LOWER;
    end else if (ctl[`LBT_BE_BIT] && upper_alpha) begin
      pick = LBT_PICK_BLEND;
    end else begin
      pick = LBT_PICK_UPPER;
    end
  end

  // One mixer per colour component
  for (genvar c = 0; c < 3; c++) begin : g_comp
    lbt_mix #(
      .W(8)
    ) u_mix (
      .upper(upper_rgb[c*8 +: 8]),
      .lower(lower_rgb[c*8 +: 8]),
      .ratio(ratio),
      .swap(ctl[`LBT_BS_BIT]),
      .result(mix_rgb[c*8 +: 8])
    );
  end

  // Output stage
  logic out_valid_q, out_valid_d;
  logic [23:0] out_rgb_q, out_rgb_d;
  logic out_blended_q, out_blended_d;

  // Compose the pixel; out_rgb and out_blended hold while no pixel arrives
  always_comb begin
    out_valid_d = pix_valid;
    out_rgb_d = out_rgb_q;
    out_blended_d = out_blended_q;
    if (pix_valid) begin
      out_blended_d = (pick == LBT_PICK_BLEND);
      case (pick)
        LBT_PICK_LOWER: out_rgb_d = lower_rgb;
        LBT_PICK_BLEND: out_rgb_d = mix_rgb;
        default: out_rgb_d = upper_rgb;
      endcase
    end
  end

  // Output flops
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      out_valid_q <= 1'b0;
      out_rgb_q <= 24'h000000;
      out_blended_q <= 1'b0;
    end else begin
      out_valid_q <= out_valid_d;
      out_rgb_q <= out_rgb_d;
      out_blended_q <= out_blended_d;
    end
  end

  assign out_valid = out_valid_q;
  assign out_rgb = out_rgb_q;
  assign out_blended = out_blended_q;

endmodule // lbt_top

// ### sim/lbt_top_chk.sv
// Concurrent checks on the ports of the layer blend block.
// Assumes a single sys_clk domain with synchronous active-high srst.
`include "lbt_defs.svh"
module lbt_top_chk #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Register bus
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  // Pixel path
  input wire logic pix_valid,
  input wire logic [3:0] top_layer_select,
  input wire logic [23:0] upper_rgb,
  input wire logic upper_alpha,
  input wire logic [23:0] lower_rgb,
  input wire logic out_valid,
  input wire logic [23:0] out_rgb,
  input wire logic out_blended
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  // A blend never leaves the span of its sources
  function automatic logic between(logic [7:0] v, logic [7:0] a,
      logic [7:0] b);
    return (v >= a && v <= b) || (v >= b && v <= a);
  endfunction

  // Word index is a known register
  function automatic logic mapped(logic [9:0] i);
    return i inside {`LBT_IDX_TC0, `LBT_IDX_TC3, `LBT_IDX_TC2,
      `LBT_IDX_BLD2, `LBT_IDX_BLD3, `LBT_IDX_BLD4, `LBT_IDX_BLD5,
      `LBT_IDX_ETC0};
  endfunction

  chk_blend_range: assert property (out_valid && out_blended |->
    between(out_rgb[23:16], $past(upper_rgb[23:16]), $past(lower_rgb[23:16]))
    && between(out_rgb[15:8], $past(upper_rgb[15:8]), $past(lower_rgb[15:8]))
    && between(out_rgb[7:0], $past(upper_rgb[7:0]), $past(lower_rgb[7:0])))
    else $error("blended pixel outside its two sources");
  chk_blend_alpha: assert property (out_valid && out_blended |->
    $past(upper_alpha) && $past(top_layer_select) inside {[4'h2:4'h5]})
    else $error("blend without alpha or blend control");
  chk_plain_layer: assert property (pix_valid &&
    top_layer_select inside {4'h1, [4'h6:4'hF]} |=> out_valid &&
    !out_blended && out_rgb == $past(upper_rgb))
    else $error("layer without control did not pass upper pixel");
  chk_no_alpha: assert property (pix_valid && !upper_alpha &&
    top_layer_select inside {4'h4, 4'h5} |=> !out_blended &&
    out_rgb == $past(upper_rgb))
    else $error("pixel without alpha was not overlaid");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid)
    else $error("read answer not one cycle after address");
  chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer changed before it was taken");
  chk_unmapped_read: assert property (s_axi_arvalid &&
    s_axi_arready && !mapped(s_axi_araddr[11:2]) |=>
    s_axi_rdata == 32'h00000000 && s_axi_rresp == `LBT_RESP_SLVERR)
    else $error("unmapped read not refused");
  chk_write_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid ##0 $stable(s_axi_bresp))
    else $error("write response dropped early");
  chk_reserved_zero: assert property (s_axi_rvalid |->
    s_axi_rdata[30:24] == 7'h00)
    else $error("reserved read bits not zero");
endmodule // lbt_top_chk

bind lbt_top lbt_top_chk #(.ADDR_W(ADDR_W)) i_lbt_top_chk (.*);

// ### sim/layer_blend_transparency_ctrl_tb.sv
// Self-checking bench for the layer blend and transparency block.
// Assumes lbt_pkg is compiled first and lbt_defs.svh is included.
`include "lbt_defs.svh"
module layer_blend_transparency_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, srst, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, pix_valid, upper_alpha;
  logic indirect_8bpp, true_color_24, out_valid, out_blended;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, top_layer_select;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [23:0] upper_rgb, upper_code, lower_rgb, out_rgb;
  logic [7:0] layer5_ratio_pix;
  logic [31:0] m [int unsigned]; // Register model; key 0 lives in ETC0
  logic [33:0] q_rd [$]; // Expected response code and read data
  logic [1:0] q_b [$]; // Expected write responses
  logic [24:0] q_px [$]; // Expected blended flag and pixel
  int err_count, num_checks;
  int unsigned ids [8] = '{`LBT_IDX_TC0, `LBT_IDX_TC3, `LBT_IDX_TC2,
    `LBT_IDX_BLD2, `LBT_IDX_BLD3, `LBT_IDX_BLD4, `LBT_IDX_BLD5,
    `LBT_IDX_ETC0};

  lbt_top i_lbt_top (.sys_clk, .srst, .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .pix_valid,
    .top_layer_select, .upper_rgb, .upper_code, .upper_alpha, .lower_rgb,
    .layer5_ratio_pix, .indirect_8bpp, .true_color_24, .out_valid,
    .out_rgb, .out_blended);

  // 100 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Compare one seen value with its note
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run
  task automatic results();
    $display("Checks %0d, errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  function automatic logic mapped(int unsigned i);
    return i inside {ids};
  endfunction

  // Writable bits; the rest read zero
  function automatic logic [31:0] wmask(int unsigned i);
    case (i)
      `LBT_IDX_BLD5: return `LBT_BLD5_MASK;
      `LBT_IDX_BLD2, `LBT_IDX_BLD3, `LBT_IDX_BLD4: return `LBT_BLD_MASK;
      `LBT_IDX_ETC0: return `LBT_ETC_MASK;
      default: return `LBT_TC_MASK;
    endcase
  endfunction

  // Short layer 0 key is a view of the extended key
  function automatic logic [31:0] mread(int unsigned i);
    logic [31:0] e;
    e = m[`LBT_IDX_ETC0];
    if (i == `LBT_IDX_TC0)
      return {16'h0000, e[31], e[14:0]};
    return m.exists(i) ? m[i] : 32'h00000000;
  endfunction

  // Byte strobes, then the mask, then the shared storage
  task automatic mwrite(input int unsigned i, input logic [31:0] d,
      input logic [3:0] s);
    logic [31:0] o, n;
    o = mread(i);
    for (int b = 0; b < 4; b++)
      n[8*b+:8] = s[b] ? d[8*b+:8] : o[8*b+:8];
    n = n & wmask(i);
    if (i == `LBT_IDX_TC0)
      m[`LBT_IDX_ETC0] = {n[15], m[`LBT_IDX_ETC0][30:15], n[14:0]};
    else
      m[i] = n;
  endtask

  // Expected pixel from the register model
  function automatic logic [24:0] compose(logic [3:0] l, logic [23:0] up,
      logic [23:0] cd, logic al, logic [23:0] lo, logic [7:0] r5,
      logic i8, logic t24);
    logic [31:0] k, c;
    logic [23:0] msk, res;
    logic zt;
    int b, w;
    k = mread(l == 0 ? `LBT_IDX_ETC0 : l == 2 ? `LBT_IDX_TC2 : `LBT_IDX_TC3);
    zt = (l == 0) ? k[31] : k[15];
    msk = i8 ? 24'h0000FF : (t24 && l == 0) ? 24'hFFFFFF : 24'h007FFF;
    if (l inside {0, 2, 3} && (((cd & msk) == 0) ? !zt :
        (cd & msk) == (k[23:0] & msk)))
      return {1'b0, lo};
    c = (l inside {[2:5]}) ? m[l == 2 ? `LBT_IDX_BLD2 :
      32'(`LBT_IDX_BLD3 + 4 * (l - 3))] : 32'h0;
    if (!(c[16] && al))
      return {1'b0, up};
    b = c[13] ? r5 : c[7:0];
    b = b + ((c[14] && b != 0) ? 1 : 0);
    w = c[15] ? 256 - b : b;
    for (int j = 0; j < 3; j++)
      res[8*j+:8] = 8'((up[8*j+:8] * w + lo[8*j+:8] * (256 - w)) >> 8);
    return {1'b1, res};
  endfunction

  // One write; bready after a random stall
  task automatic axw(input int unsigned i, input logic [31:0] d,
      input logic [3:0] s);
    logic aw, wd;
    aw = 1'b1;
    wd = 1'b1;
    q_b.push_back(mapped(i) ? `LBT_RESP_OKAY : `LBT_RESP_SLVERR);
    if (mapped(i))
      mwrite(i, d, s);
    s_axi_awaddr <= 12'(4 * i);
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (aw || wd) begin
      @(posedge sys_clk);
      if (aw && s_axi_awready === 1'b1) begin
        s_axi_awvalid <= 1'b0;
        aw = 1'b0;
      end
      if (wd && s_axi_wready === 1'b1) begin
        s_axi_wvalid <= 1'b0;
        wd = 1'b0;
      end
    end
    repeat ($urandom_range(0, 2)) @(posedge sys_clk);
    s_axi_bready <= 1'b1;
    do @(posedge sys_clk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    @(posedge sys_clk);
  endtask

  // One read; rready after a random stall
  task automatic axr(input int unsigned i);
    q_rd.push_back({mapped(i) ? `LBT_RESP_OKAY : `LBT_RESP_SLVERR,
      mread(i)});
    s_axi_araddr <= 12'(4 * i);
    s_axi_arvalid <= 1'b1;
    do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    repeat ($urandom_range(0, 2)) @(posedge sys_clk);
    s_axi_rready <= 1'b1;
    do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    @(posedge sys_clk);
  endtask

  // One pixel; code is random, zero, the layer's key, or the key with bit 0 flipped
  task automatic px(input logic [3:0] l, input logic al, input int cm);
    logic [23:0] up, lo, cd;
    logic [7:0] r5;
    logic i8, t24;
    up = 24'($urandom);
    lo = 24'($urandom);
    r5 = 8'($urandom);
    i8 = 1'($urandom);
    t24 = !i8 && 1'($urandom);
    cd = cm == 0 ? 24'($urandom) : cm == 1 ? 24'h000000 : mread(l == 0 ?
      `LBT_IDX_ETC0 : l == 2 ? `LBT_IDX_TC2 : `LBT_IDX_TC3) ^ 24'(cm - 2);
    q_px.push_back(compose(l, up, cd, al, lo, r5, i8, t24));
    pix_valid <= 1'b1;
    top_layer_select <= l;
    upper_rgb <= up;
    upper_code <= cd;
    upper_alpha <= al;
    lower_rgb <= lo;
    layer5_ratio_pix <= r5;
    indirect_8bpp <= i8;
    true_color_24 <= t24;
    @(posedge sys_clk);
  endtask

  // Watcher: oldest note against each answer
  always @(posedge sys_clk) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
      check({s_axi_rresp, s_axi_rdata}, q_rd.pop_front());
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
      check(34'(s_axi_bresp), 34'(q_b.pop_front()));
    if (out_valid === 1'b1)
      check(34'({out_blended, out_rgb}), 34'(q_px.pop_front()));
  end

  // Watchdog, far past the run's length
  initial begin
    repeat (60000) @(posedge sys_clk);
    err_count++;
    results();
  end

  // Main sequence
  initial begin
    void'($urandom(32'hC72CD4E7));
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
    {s_axi_rready, pix_valid, upper_alpha, indirect_8bpp} = 4'h0;
    {true_color_24, s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = 29'h0;
    {s_axi_wdata, top_layer_select, layer5_ratio_pix} = 44'h0;
    {upper_rgb, upper_code, lower_rgb} = 72'h0;
    foreach (ids[n])
      m[ids[n]] = 32'h00000000;
    srst = 1'b1;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    foreach (ids[n])
      axr(ids[n]);
    axw(32'h0BD, 32'hFFFFFFFF, 4'hF);
    axr(32'h0BD);
    // Ones then zeros into each register, all read back
    for (int v = 0; v < 16; v++) begin
      axw(ids[v % 8], v < 8 ? 32'hFFFFFFFF : 32'h0, 4'hF);
      foreach (ids[n])
        axr(ids[n]);
    end
    // Every blend control at both ratio ends
    for (int v = 0; v < 128; v++) begin
      axw(v[1:0] == 0 ? `LBT_IDX_BLD2 : 32'(`LBT_IDX_BLD3 + 4 * (v[1:0] - 1)),
        {15'h0, v[6:3], 5'h00, {8{v[2]}}}, 4'hF);
      px(4'(2 + v[1:0]), 1'b1, 0);
      px(4'(2 + v[1:0]), 1'b0, 0);
      pix_valid <= 1'b0;
    end
    // Random registers, strobes and pixels
    repeat (40) begin
      repeat (3)
        axw(ids[$urandom_range(0, 7)], $urandom, 4'($urandom));
      axr(ids[$urandom_range(0, 7)]);
      repeat (16)
        px(4'($urandom_range(0, 7)), 1'($urandom), $urandom_range(0, 3));
      pix_valid <= 1'b0;
    end
    repeat (4) @(posedge sys_clk);
    check(34'(q_px.size() + q_rd.size() + q_b.size()), 34'h0);
    results();
  end
endmodule // layer_blend_transparency_ctrl_tb
